// ### src/rtc_regs_defines.vh
// register offsets, field positions and timing counts of the calendar register bank
`ifndef RTC_REGS_DEFINES_VH
`define RTC_REGS_DEFINES_VH

// byte offsets on the bus
`define OFF_CLK_SEC      12'h000
`define OFF_CLK_HM       12'h004
`define OFF_CLK_DW       12'h008
`define OFF_CLK_YM       12'h00C
`define OFF_ALM_SEC      12'h010
`define OFF_ALM_HM       12'h014
`define OFF_ALM_DW       12'h018
`define OFF_ALM_YM       12'h01C
`define OFF_STP_SEC      12'h020
`define OFF_STP_HM       12'h024
`define OFF_STP_DW       12'h028
`define OFF_STP_YM       12'h02C
`define OFF_CTRL         12'h030
`define OFF_STATUS       12'h034
`define OFF_INT_MASK     12'h038

// implemented bits of each word kind
`define MASK_SEC         16'h7F00
`define MASK_HM          16'h3F7F
`define MASK_DW          16'h3F07
`define MASK_YM          16'hFF1F

// status bits
`define ST_UNSAFE        0
`define ST_HALF          1
`define ST_STAMP_EVT     2
`define ST_SECOND_EVT    3

// control bits
`define CTRL_STAMP_EN    0
`define CTRL_RUN         1
`define CTRL_STAMP_SW    2

// timebase: half-second tick at 25 MHz
`define CLOCK_HZ         25000000
`define HALF_SEC_CYCLES  (`CLOCK_HZ / 2)

`endif

// ### src/calendar_value_alarm_stamp_regs.v
// real-time clock calendar value, alarm and timestamp register bank with an apb slave
`timescale 1ns/10ps
`include "rtc_regs_defines.vh"

// Contract
// - seconds tens 14-12, units 11-8
// - minutes tens 6-4, units 3-0
// - hours tens 13-12, units 11-8
// - day tens 13-12, units 11-8
// - weekday 0 to 6 in bits 2-0
// - month tens bit 4, units 3-0
// - year tens 15-12, units 11-8
// - unassigned bits read zero, ignore writes; timestamp words store all 16 bits while capture is off
// - alarm words mirror layout, read-write, reset zero
// - timestamp words mirror layout, reset zero
// - timestamp words keep data through warm reset
// - unsafe flag while live time may change
// - seconds units write clears half-second flag
// - stamp event copies time, sets flag
module calendar_value_alarm_stamp_regs #(
    parameter HALF_SEC_CYCLES = `HALF_SEC_CYCLES
) (
    // clock and resets
    input  wire        clock,
    input  wire        rst,
    input  wire        por,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // external timestamp trigger, active low pulse
    input  wire        stamp_trigger_n,
    // interrupt
    output wire        irq
);

    // bcd increment with wrap; returns carry in bit 4
    function [4:0] bcd_step;
        input [3:0] val;
        input [3:0] max;
        input [3:0] minv;
        begin
            if (val >= max)
                bcd_step = {1'b1, minv};
            else
                bcd_step = {1'b0, val + 4'h1};
        end
    endfunction

    // two-digit bcd increment: {carry, tens, units}
    function [8:0] bcd2_step;
        input [7:0] val;
        input [7:0] max;
        input [7:0] minv;
        begin
            if (val >= max)
                bcd2_step = {1'b1, minv};
            else if (val[3:0] == 4'h9)
                bcd2_step = {1'b0, val[7:4] + 4'h1, 4'h0};
            else
                bcd2_step = {1'b0, val[7:4], val[3:0] + 4'h1};
        end
    endfunction

    // last day of the month in bcd; a year divisible by four counts as leap
    function [7:0] month_last_day;
        input [4:0] month;
        input [7:0] year;
        reg         leap;
        begin
            // bcd multiple of four: even tens with units 0/4/8, odd tens with units 2/6
            leap = year[4] ? (year[1:0] == 2'b10) : (year[1:0] == 2'b00);
            case (month)
                5'h02:   month_last_day = leap ? 8'h29 : 8'h28;
                5'h04,
                5'h06,
                5'h09,
                5'h11:   month_last_day = 8'h30;
                default: month_last_day = 8'h31;
            endcase
        end
    endfunction

    // stamp words keep all 16 bits as storage while capture is off
    function [15:0] stamp_store;
        input        capture_on;
        input [15:0] data;
        input [15:0] layout;
        begin
            stamp_store = capture_on ? (data & layout) : data;
        end
    endfunction

    // live time and date words
    reg  [15:0] clk_sec_q;
    reg  [15:0] clk_hm_q;
    reg  [15:0] clk_dw_q;
    reg  [15:0] clk_ym_q;
    // alarm and timestamp words
    reg  [15:0] alarm_seconds_word_q;
    reg  [15:0] alarm_hours_minutes_word_q;
    reg  [15:0] alarm_day_weekday_word_q;
    reg  [15:0] alarm_year_month_word_q;
    reg  [15:0] stamp_seconds_word_q;
    reg  [15:0] stamp_hours_minutes_word_q;
    reg  [15:0] stamp_day_weekday_word_q;
    reg  [15:0] stamp_year_month_word_q;
    // control and status
    reg  [1:0]  ctrl_q;
    reg  [3:0]  mask_q;
    reg  [3:0]  sticky_q;
    reg         half_second_flag_q;
    reg  [23:0] div_q;
    reg         trig_n_q;

    wire        wr = psel && penable && pwrite;
    wire        rd = psel && penable && !pwrite;
    // read data is latched in the setup phase so it stands through the access phase
    wire        rd_setup   = psel && !penable && !pwrite;
    // status read in the access phase clears the sticky bits
    wire        rd_status  = rd && (paddr == `OFF_STATUS);
    // per-word write strobes, all taken in the access phase
    wire        wr_clk_sec = wr && (paddr == `OFF_CLK_SEC);
    wire        wr_clk_hm  = wr && (paddr == `OFF_CLK_HM);
    wire        wr_clk_dw  = wr && (paddr == `OFF_CLK_DW);
    wire        wr_clk_ym  = wr && (paddr == `OFF_CLK_YM);
    // alarm compare word strobes
    wire        wr_alm_sec = wr && (paddr == `OFF_ALM_SEC);
    wire        wr_alm_hm  = wr && (paddr == `OFF_ALM_HM);
    wire        wr_alm_dw  = wr && (paddr == `OFF_ALM_DW);
    wire        wr_alm_ym  = wr && (paddr == `OFF_ALM_YM);
    // timestamp word strobes
    wire        wr_stp_sec = wr && (paddr == `OFF_STP_SEC);
    wire        wr_stp_hm  = wr && (paddr == `OFF_STP_HM);
    wire        wr_stp_dw  = wr && (paddr == `OFF_STP_DW);
    wire        wr_stp_ym  = wr && (paddr == `OFF_STP_YM);
    // control and mask strobes
    wire        wr_ctrl    = wr && (paddr == `OFF_CTRL);
    wire        wr_mask    = wr && (paddr == `OFF_INT_MASK);
    wire        stamp_capture_enable = ctrl_q[`CTRL_STAMP_EN];
    wire        running = ctrl_q[`CTRL_RUN];
    wire        half_tick = running && (div_q == HALF_SEC_CYCLES - 1);
    wire        sec_tick = half_tick && half_second_flag_q;
    // unsafe while a rollover is at most two cycles away
    wire        alarm_update_unsafe_flag = running && (div_q >= HALF_SEC_CYCLES - 2) && half_second_flag_q;
    wire        hw_trig = trig_n_q && !stamp_trigger_n;
    // the request bit only counts once capture is already enabled
    wire        sw_trig = wr_ctrl && pwdata[`CTRL_STAMP_SW];
    // capture blocked until software clears the event flag
    wire        stamp_go = stamp_capture_enable && !sticky_q[`ST_STAMP_EVT] && (hw_trig || sw_trig);
    // sticky set pattern in status layout: bit 3 second tick, bit 2 stamp event
    wire [3:0]  events = {sec_tick, stamp_go, 2'b00};

    // single-cycle apb answer
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign irq     = |(sticky_q & mask_q);

    // next calendar values
    reg  [15:0] nsec;
    reg  [15:0] nhm;
    reg  [15:0] ndw;
    reg  [15:0] nym;
    reg  [4:0]  su;
    reg  [4:0]  st;
    reg  [4:0]  mu;
    reg  [4:0]  mt;
    reg  [8:0]  hh;
    reg  [8:0]  dd;
    reg  [4:0]  wd;
    reg  [8:0]  mm;
    reg  [8:0]  yy;
    reg  [7:0]  mdays;

    // bcd advance with carries; day limit tracks month and leap year
    always @* begin
        mdays = month_last_day(clk_ym_q[4:0], clk_ym_q[15:8]);
        su = bcd_step(clk_sec_q[11:8], 4'h9, 4'h0);
        st = bcd_step({1'b0, clk_sec_q[14:12]}, 4'h5, 4'h0);
        mu = bcd_step(clk_hm_q[3:0], 4'h9, 4'h0);
        mt = bcd_step({1'b0, clk_hm_q[6:4]}, 4'h5, 4'h0);
        hh = bcd2_step({2'b00, clk_hm_q[13:8]}, 8'h23, 8'h00);
        dd = bcd2_step({2'b00, clk_dw_q[13:8]}, mdays, 8'h01);
        wd = bcd_step({1'b0, clk_dw_q[2:0]}, 4'h6, 4'h0);
        mm = bcd2_step({3'b000, clk_ym_q[4:0]}, 8'h12, 8'h01);
        yy = bcd2_step(clk_ym_q[15:8], 8'h99, 8'h00);
        nsec = clk_sec_q;
        nhm  = clk_hm_q;
        ndw  = clk_dw_q;
        nym  = clk_ym_q;
        nsec[11:8] = su[3:0];
        if (su[4]) begin
            nsec[14:12] = st[2:0];
            if (st[4]) begin
                nhm[3:0] = mu[3:0];
                if (mu[4]) begin
                    nhm[6:4] = mt[2:0];
                    if (mt[4]) begin
                        nhm[13:8] = hh[5:0];
                        if (hh[8]) begin
                            ndw[13:8] = dd[5:0];
                            ndw[2:0]  = wd[2:0];
                            if (dd[8]) begin
                                nym[4:0] = mm[4:0];
                                if (mm[8])
                                    nym[15:8] = yy[7:0];
                            end
                        end
                    end
                end
            end
        end
    end

    // live time: only the documented top bits are cleared at power-on, the rest stay undefined
    always @(posedge clock) begin
        if (por) begin
            clk_hm_q[13]  <= 1'b0;
            clk_hm_q[6:5] <= 2'b00;
            clk_dw_q[13:8] <= 6'h00;
            clk_ym_q[15:12] <= 4'h0;
        end else if (wr_clk_sec) begin
            clk_sec_q <= pwdata[15:0] & `MASK_SEC;
        end else if (wr_clk_hm) begin
            clk_hm_q <= pwdata[15:0] & `MASK_HM;
        end else if (wr_clk_dw) begin
            clk_dw_q <= pwdata[15:0] & `MASK_DW;
        end else if (wr_clk_ym) begin
            clk_ym_q <= pwdata[15:0] & `MASK_YM;
        end else if (sec_tick) begin
            clk_sec_q <= nsec;
            clk_hm_q  <= nhm;
            clk_dw_q  <= ndw;
            clk_ym_q  <= nym;
        end
    end

    // alarm compare words, cleared only at power-on
    always @(posedge clock) begin
        if (por) begin
            alarm_seconds_word_q       <= 16'h0000;
            alarm_hours_minutes_word_q <= 16'h0000;
            alarm_day_weekday_word_q   <= 16'h0000;
            alarm_year_month_word_q    <= 16'h0000;
        end else begin
            if (wr_alm_sec) begin
                alarm_seconds_word_q <= pwdata[15:0] & `MASK_SEC;
            end
            if (wr_alm_hm) begin
                alarm_hours_minutes_word_q <= pwdata[15:0] & `MASK_HM;
            end
            if (wr_alm_dw) begin
                alarm_day_weekday_word_q <= pwdata[15:0] & `MASK_DW;
            end
            if (wr_alm_ym) begin
                alarm_year_month_word_q <= pwdata[15:0] & `MASK_YM;
            end
        end
    end

    // timestamp words: all 16 bits are storage while capture is off, survive warm reset
    always @(posedge clock) begin
        if (por) begin
            stamp_seconds_word_q       <= 16'h0000;
            stamp_hours_minutes_word_q <= 16'h0000;
            stamp_day_weekday_word_q   <= 16'h0000;
            stamp_year_month_word_q    <= 16'h0000;
        end else if (stamp_go) begin
            stamp_seconds_word_q       <= clk_sec_q;
            stamp_hours_minutes_word_q <= clk_hm_q;
            stamp_day_weekday_word_q   <= clk_dw_q;
            stamp_year_month_word_q    <= clk_ym_q;
        end else begin
            // a capture in the same cycle wins over a software write
            if (wr_stp_sec) begin
                stamp_seconds_word_q <= stamp_store(stamp_capture_enable, pwdata[15:0], `MASK_SEC);
            end
            if (wr_stp_hm) begin
                stamp_hours_minutes_word_q <= stamp_store(stamp_capture_enable, pwdata[15:0], `MASK_HM);
            end
            if (wr_stp_dw) begin
                stamp_day_weekday_word_q <= stamp_store(stamp_capture_enable, pwdata[15:0], `MASK_DW);
            end
            if (wr_stp_ym) begin
                stamp_year_month_word_q <= stamp_store(stamp_capture_enable, pwdata[15:0], `MASK_YM);
            end
        end
    end

    // control and mask; warm reset clears them but leaves stamp words alone
    always @(posedge clock) begin
        if (rst || por) begin
            ctrl_q <= 2'b00;
            mask_q <= 4'h0;
        end else begin
            // the software capture bit is a strobe and is not stored
            if (wr_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (wr_mask) begin
                mask_q <= pwdata[3:0];
            end
        end
    end

    // trigger pin history; reset to the idle level so no false edge follows reset
    always @(posedge clock) begin
        if (rst || por) begin
            trig_n_q <= 1'b1;
        end else begin
            trig_n_q <= stamp_trigger_n;
        end
    end

    // half-second divider; a seconds write restarts the phase so software can align it
    always @(posedge clock) begin
        if (rst || por) begin
            half_second_flag_q <= 1'b0;
            div_q              <= 24'h00_0000;
        end else if (wr_clk_sec) begin
            half_second_flag_q <= 1'b0;
            div_q              <= 24'h00_0000;
        end else if (half_tick) begin
            half_second_flag_q <= !half_second_flag_q;
            div_q              <= 24'h00_0000;
        end else if (running) begin
            div_q <= div_q + 24'h00_0001;
        end
    end

    // sticky events; a status read clears them, but a same-cycle event still wins
    always @(posedge clock) begin
        if (rst || por) begin
            sticky_q <= 4'h0;
        end else if (rd_status) begin
            sticky_q <= events;
        end else begin
            sticky_q <= sticky_q | events;
        end
    end

    // read mux; unmapped addresses read zero
    always @(posedge clock) begin
        if (rst || por) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            case (paddr)
                `OFF_CLK_SEC: prdata <= {16'h0000, clk_sec_q & `MASK_SEC};
                `OFF_CLK_HM:  prdata <= {16'h0000, clk_hm_q & `MASK_HM};
                `OFF_CLK_DW:  prdata <= {16'h0000, clk_dw_q & `MASK_DW};
                `OFF_CLK_YM:  prdata <= {16'h0000, clk_ym_q & `MASK_YM};
                `OFF_ALM_SEC: prdata <= {16'h0000, alarm_seconds_word_q};
                `OFF_ALM_HM:  prdata <= {16'h0000, alarm_hours_minutes_word_q};
                `OFF_ALM_DW:  prdata <= {16'h0000, alarm_day_weekday_word_q};
                `OFF_ALM_YM:  prdata <= {16'h0000, alarm_year_month_word_q};
                `OFF_STP_SEC: prdata <= {16'h0000, stamp_seconds_word_q};
                `OFF_STP_HM:  prdata <= {16'h0000, stamp_hours_minutes_word_q};
                `OFF_STP_DW:  prdata <= {16'h0000, stamp_day_weekday_word_q};
                `OFF_STP_YM:  prdata <= {16'h0000, stamp_year_month_word_q};
                `OFF_CTRL:    prdata <= {30'h0000_0000, ctrl_q};
                `OFF_STATUS:  prdata <= {28'h000_0000, sticky_q[3], sticky_q[2],
                                         half_second_flag_q, alarm_update_unsafe_flag};
                `OFF_INT_MASK: prdata <= {28'h000_0000, mask_q};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ### test/rtc_regs_chk.sv
// assertion checker for the calendar register bank
`timescale 1ns/10ps
`include "rtc_regs_defines.vh"
module rtc_regs_chk #(
    parameter HALF_SEC_CYCLES = 8
) (
    // clock and resets
    input wire        clock,
    input wire        rst,
    input wire        por,
    // apb and side pins
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        stamp_trigger_n,
    input wire        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst || por);
    wire        rd = psel && !penable && !pwrite;
    wire        wr = psel && penable && pwrite;
    reg         alm_z_q, stp_z_q, wv_q, sv_q;
    reg  [11:0] wa_q;
    reg  [15:0] wd_q;
    reg  [3:0]  hs_q;
    function [15:0] fmask(input [1:0] k);
        fmask = k == 0 ? `MASK_SEC : k == 1 ? `MASK_HM : k == 2 ? `MASK_DW : `MASK_YM;
    endfunction
    // track what the words must hold; stamp zero only until any capture could happen
    always @(posedge clock) begin
        if (por) begin
            alm_z_q <= 1'b1;
            stp_z_q <= 1'b1;
            wv_q    <= 1'b0;
            sv_q    <= 1'b0;
        end else begin
            if (wr && paddr[11:4] == 8'h01) alm_z_q <= 1'b0;
            if ((wr && paddr[11:4] >= 8'h02) || !stamp_trigger_n) stp_z_q <= 1'b0;
            if (wr) wv_q <= paddr[11:4] == 8'h01;
            if (wr && paddr == `OFF_CLK_SEC) sv_q <= 1'b1;
        end
        if (wr) wa_q <= paddr;
        if (wr) wd_q <= pwdata[15:0];
        if (wr && paddr == `OFF_CLK_SEC) hs_q <= 4'h0;
        else if (hs_q != 4'hF) hs_q <= hs_q + 4'h1;
    end
    property p_upper; rd |=> prdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    property p_layout; rd && paddr < 12'h020 |=> (prdata[15:0] & ~fmask($past(paddr[3:2]))) == 16'h0000; endproperty
    a_layout: assert property (p_layout) else $error("unassigned bit set");
    property p_unmapped; rd && paddr > `OFF_INT_MASK |=> prdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_alm_zero; rd && alm_z_q && paddr[11:4] == 8'h01 |=> prdata == 32'h0000_0000; endproperty
    a_alm_zero: assert property (p_alm_zero) else $error("alarm word not cleared");
    property p_stp_zero; rd && stp_z_q && paddr[11:4] == 8'h02 |=> prdata == 32'h0000_0000; endproperty
    a_stp_zero: assert property (p_stp_zero) else $error("stamp word not cleared");
    property p_alm_rb; rd && wv_q && paddr == wa_q |=> prdata[15:0] == (wd_q & fmask(wa_q[3:2])); endproperty
    a_alm_rb: assert property (p_alm_rb) else $error("alarm readback wrong");
    property p_half; rd && sv_q && hs_q < 4'h4 && paddr == `OFF_STATUS |=> !prdata[`ST_HALF]; endproperty
    a_half: assert property (p_half) else $error("half second flag after write");
    property p_resp; psel && penable |-> pready && !pslverr; endproperty
    a_resp: assert property (p_resp) else $error("transfer stalled or refused");
    property p_unsafe; rd && paddr == `OFF_STATUS |=> !prdata[`ST_UNSAFE] || prdata[`ST_HALF]; endproperty
    a_unsafe: assert property (p_unsafe) else $error("unsafe flag outside second half");
    c_unsafe: cover property (rd && paddr == `OFF_STATUS ##1 prdata[`ST_UNSAFE]);
    c_stamp: cover property (rd && paddr == `OFF_STATUS ##1 prdata[`ST_STAMP_EVT]);
    c_irq: cover property ($rose(irq));
    c_alm: cover property (rd && wv_q);
endmodule
bind calendar_value_alarm_stamp_regs rtc_regs_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) u_chk (.clock, .rst, .por,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .stamp_trigger_n, .irq);

// ### test/tb_calendar_value_alarm_stamp_regs.sv
// self-checking bench for the calendar register bank
`timescale 1ns/10ps
`include "rtc_regs_defines.vh"
module tb_calendar_value_alarm_stamp_regs;
    logic        clock = 0, rst = 1, por = 1, psel = 0, penable = 0, pwrite = 0, stamp_trigger_n = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, seed = 44181, d;
    logic [63:0] note;
    logic [63:0] notes[$];
    logic [15:0] sv[4];
    logic [15:0] wm[4] = '{`MASK_SEC, `MASK_HM, `MASK_DW, `MASK_YM};
    wire         pready, pslverr, irq;
    wire  [31:0] prdata;
    int          n_errors = 0, checked = 0, i;
    calendar_value_alarm_stamp_regs #(.HALF_SEC_CYCLES(8)) u_dut (.clock, .rst, .por, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .stamp_trigger_n, .irq);
    initial forever #20 clock = ~clock;
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task tally_and_finish;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input [11:0] a, input w, input [31:0] v);
        int k;
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= v;
        @(posedge clock);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (!pready && k < 50);
        if (!pready) begin
            n_errors++;
            tally_and_finish;
        end
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask
    task rd(input [11:0] a, input [31:0] e, input [31:0] m);
        notes.push_back({m, e & m});
        apb(a, 0, '0);
    endtask
    // the oldest note is matched against each read answer
    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready && notes.size() > 0) begin
            note = notes.pop_front();
            chk(prdata & note[63:32], note[31:0]);
        end
    end
    task trig;
        stamp_trigger_n <= 0;
        repeat (2) @(posedge clock);
        stamp_trigger_n <= 1;
        @(posedge clock);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 0;
        por <= 0;
        @(posedge clock);
        rd(`OFF_CLK_HM, '0, 32'hFFFF_E0E0);
        rd(`OFF_CLK_DW, '0, 32'hFFFF_FFF8);
        for (int k = 0; k < 4; k++) begin
            rd(12'(`OFF_ALM_SEC + 4 * k), '0, '1);
            rd(12'(`OFF_STP_SEC + 4 * k), '0, '1);
            d = xs();
            apb(12'(`OFF_ALM_SEC + 4 * k), 1, d);
            rd(12'(`OFF_ALM_SEC + 4 * k), {16'h0000, d[15:0] & wm[k]}, '1);
            sv[k] = d[31:16];
            apb(12'(`OFF_STP_SEC + 4 * k), 1, {16'h0000, sv[k]});
        end
        // warm reset keeps stored stamp words
        rst <= 1;
        repeat (3) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        for (int k = 0; k < 4; k++) rd(12'(`OFF_STP_SEC + 4 * k), {16'h0000, sv[k]}, '1);
        rd(12'h03C, '0, '1);
        apb(`OFF_CLK_SEC, 1, 32'h0000_5900);
        rd(`OFF_STATUS, '0, 32'h0000_0002);
        apb(`OFF_CLK_HM, 1, 32'h0000_2359);
        apb(`OFF_CLK_DW, 1, 32'h0000_3106);
        apb(`OFF_CLK_YM, 1, 32'h0000_9912);
        apb(`OFF_INT_MASK, 1, 32'h0000_000C);
        apb(`OFF_CTRL, 1, 32'h0000_0002);
        // wait for the second tick, then stop the count
        for (i = 0; i < 100 && !irq; i++) @(posedge clock);
        chk(irq, 1);
        if (!irq) tally_and_finish;
        apb(`OFF_CTRL, 1, 32'h0000_0000);
        rd(`OFF_STATUS, 32'h0000_0008, 32'h0000_0008);
        chk(irq, 0);
        rd(`OFF_CLK_SEC, '0, '1);
        rd(`OFF_CLK_HM, '0, '1);
        rd(`OFF_CLK_DW, 32'h0000_0100, '1);
        rd(`OFF_CLK_YM, 32'h0000_0001, '1);
        // capture must already be on when the software request arrives
        apb(`OFF_CTRL, 1, 32'h0000_0001);
        apb(`OFF_CTRL, 1, 32'h0000_0005);
        chk(irq, 1);
        rd(`OFF_STP_DW, 32'h0000_0100, '1);
        rd(`OFF_STP_YM, 32'h0000_0001, '1);
        rd(`OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
        apb(`OFF_CLK_SEC, 1, 32'h0000_3700);
        trig();
        apb(`OFF_CLK_SEC, 1, 32'h0000_1200);
        trig();
        rd(`OFF_STP_SEC, 32'h0000_3700, '1);
        // run again and poll status until the unsafe flag shows; it must sit in the second half
        apb(`OFF_CTRL, 1, 32'h0000_0002);
        for (i = 0; i < 40 && !prdata[`ST_UNSAFE]; i++) apb(`OFF_STATUS, 0, '0);
        chk(prdata[1:0], 2'b11);
        tally_and_finish;
    end
endmodule
